// file: rtl/uart_tx_pkg.sv
/*
  Shared constants for the asynchronous serial transmitter: register
  indices and byte addresses, field positions, reset values, masks,
  oversample counts and the transmit state encoding.
  Assumes a word-addressed register map with 32-bit Wishbone data, where
  each register index becomes byte address index * 4.
*/
package uart_tx_pkg;

  localparam int WB_ADR_W = 10;
  localparam int WB_DAT_W = 32;
  localparam int WB_SEL_W = 4;
  localparam int DIV_W_DEF = 8;

  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_RCTL = 8'h18;
  localparam logic [7:0] IDX_TXBUF = 8'h19;
  localparam logic [7:0] IDX_IEN = 8'h8c;
  localparam logic [7:0] IDX_TXCTL = 8'h98;
  localparam logic [7:0] IDX_DIV = 8'h99;

  localparam logic [WB_ADR_W-1:0] ADR_FLAGS = {IDX_FLAGS, 2'h0};
  localparam logic [WB_ADR_W-1:0] ADR_RCTL = {IDX_RCTL, 2'h0};
  localparam logic [WB_ADR_W-1:0] ADR_TXBUF = {IDX_TXBUF, 2'h0};
  localparam logic [WB_ADR_W-1:0] ADR_IEN = {IDX_IEN, 2'h0};
  localparam logic [WB_ADR_W-1:0] ADR_TXCTL = {IDX_TXCTL, 2'h0};
  localparam logic [WB_ADR_W-1:0] ADR_DIV = {IDX_DIV, 2'h0};

  // field positions
  localparam int FLAG_TXE_BIT = 4;
  localparam int IEN_TXE_BIT = 4;
  localparam int TXC_CSRC = 7;
  localparam int TXC_NINE = 6;
  localparam int TXC_EN = 5;
  localparam int TXC_SYNC = 4;
  localparam int TXC_HS = 2;
  localparam int TXC_EMPTY = 1;
  localparam int TXC_D9 = 0;
  localparam int RC_PORT_EN = 7;

  // reset values
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_RCTL = 8'h00;
  localparam logic [7:0] RST_TXBUF = 8'h00;
  localparam logic [7:0] RST_IEN = 8'h00;
  localparam logic [7:0] RST_TXCTL = 8'h02;
  localparam logic [7:0] RST_DIV = 8'h00;

  // writable bits; the rest read as zero or as live status
  localparam logic [7:0] RCTL_WR_MASK = 8'hf8;
  localparam logic [7:0] IEN_WR_MASK = 8'hf7;
  localparam logic [7:0] TXCTL_WR_MASK = 8'hf5;

  // oversample prescaler terminal counts: x16 and x64 of the bit rate
  localparam logic [5:0] PRESC_HS_LAST = 6'h0f;
  localparam logic [5:0] PRESC_LS_LAST = 6'h3f;

  // index of the last data bit for 8- and 9-bit frames
  localparam logic [3:0] DATA_LAST_8 = 4'h7;
  localparam logic [3:0] DATA_LAST_9 = 4'h8;

  typedef enum logic [1:0] {
    TX_IDLE = 2'h0,
    TX_START = 2'h1,
    TX_DATA = 2'h3,
    TX_STOP = 2'h2
  } tx_state_t;

endpackage : uart_tx_pkg

// file: rtl/baud_gen.sv
/*
  Baud generator: a free-running divisor timer followed by an x16 or x64
  oversample prescaler, giving one bit_tick pulse per bit time.
  Assumes divisor_in comes from a register on the same clock and that
  div_write_in pulses for one cycle when software writes that register.
*/
`timescale 1ns/1ps
module baud_gen #(
  parameter int DIV_W = uart_tx_pkg::DIV_W_DEF
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic [DIV_W-1:0] divisor_in,
  input wire logic div_write_in,
  input wire logic high_speed_in,
  input wire logic halt_in,
  output logic bit_tick_out
);
  import uart_tx_pkg::*;

  if (DIV_W < 1 || DIV_W > 8) begin : g_bad_width
    $error("baud_gen: DIV_W must lie between 1 and 8");
  end

  typedef struct packed {
    logic [DIV_W-1:0] timer;
    logic [5:0] presc;
    logic tick;
  } baud_regs_t;

  localparam baud_regs_t B_RESET = '{timer: '0, presc: 6'h00, tick: 1'b0};

  baud_regs_t s;
  baud_regs_t n;
  logic [5:0] presc_last;

  assign presc_last = high_speed_in ? PRESC_HS_LAST : PRESC_LS_LAST;

  always_comb begin
    n = s;
    n.tick = 1'b0;
    if (div_write_in) begin
      n.timer = '0;
      n.presc = 6'h00;
    end else if (!halt_in) begin
      if (s.timer == divisor_in) begin
        n.timer = '0;
        // rate is clock over ratio times divisor plus one
        if (s.presc >= presc_last) begin
          n.presc = 6'h00;
          n.tick = 1'b1;
        end else begin
          n.presc = s.presc + 6'h01;
        end
      end else begin
        n.timer = s.timer + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s <= B_RESET;
    end else begin
      s <= n;
    end
  end

  assign bit_tick_out = s.tick;

  div_clear_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    div_write_in |=> (s.timer == '0) && (s.presc == 6'h00) && !s.tick
  ) else $error("divisor write did not clear the timer");

  timer_run_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (!div_write_in && !halt_in && s.timer != divisor_in)
      |=> s.timer == $past(s.timer) + 1'b1
  ) else $error("divisor timer did not advance");

  tick_ratio_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    s.tick |-> $past(s.presc) >= $past(presc_last)
  ) else $error("bit tick not at the oversample terminal count");

endmodule : baud_gen

// file: rtl/async_serial_transmitter.sv
/*
  Asynchronous serial transmitter with its register file on a classic
  Wishbone slave: holding buffer, shift register, buffer-empty flag,
  shift-empty status, abort on disable and optional ninth bit.
  Assumes a single 40 MHz clock that also serves as oscillator and
  instruction clock, a same-clock sleep level and a pad that resolves
  the transmit pin from its output enable.
*/
// Function
// - frame: start, eight or nine data, stop
// - data bits leave least significant first
// - transmit and receive share format and rate
// - 8-bit divisor timer free-runs from divisor
// - x16 with high speed, x64 otherwise
// - no hardware parity; ninth bit from software
// - sleep halts all asynchronous operation
// - clocked-mode bit zero selects asynchronous mode
// - shift register loads only after stop bit
// - buffer to shift register move sets flag
// - flag cleared only by buffer write
// - readable status shows shift register empty
// - setting transmit enable sets the flag
// - frame needs enable, data and shift clock
// - write to empty path passes straight through
// - clearing enable aborts, pin floats
// - rate is clock over 64 or 16 times divisor+1
// - divisor write clears the divisor timer
// - pin serves the port only when port enabled
`timescale 1ns/1ps
module async_serial_transmitter #(
  parameter int DIV_W = uart_tx_pkg::DIV_W_DEF
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [uart_tx_pkg::WB_ADR_W-1:0] wb_adr_in,
  input wire logic [uart_tx_pkg::WB_SEL_W-1:0] wb_sel_in,
  input wire logic [uart_tx_pkg::WB_DAT_W-1:0] wb_dat_in,
  output logic [uart_tx_pkg::WB_DAT_W-1:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic sleep_in,
  output logic tx_pin_out,
  output logic tx_pin_oe_out
);
  import uart_tx_pkg::*;

  if (DIV_W < 1 || DIV_W > 8) begin : g_bad_width
    $error("async_serial_transmitter: DIV_W must lie between 1 and 8");
  end

  typedef struct packed {
    logic ack;
    logic [7:0] rdat;
    logic [7:0] rctl;
    logic [7:0] ien;
    logic [7:0] txctl;
    logic [7:0] div;
    logic [7:0] hb;
    logic hb_full;
    logic flag;
    logic [8:0] transmit_shift_register;
    logic tsr_full;
    logic [3:0] cnt;
    logic [3:0] last;
    tx_state_t state;
    logic line;
    logic oe;
  } tx_regs_t;

  localparam tx_regs_t S_RESET = '{
    ack: 1'b0,
    rdat: 8'h00,
    rctl: RST_RCTL,
    ien: RST_IEN,
    txctl: RST_TXCTL & TXCTL_WR_MASK,
    div: RST_DIV,
    hb: RST_TXBUF,
    hb_full: 1'b0,
    flag: RST_FLAGS[FLAG_TXE_BIT],
    transmit_shift_register: 9'h000,
    tsr_full: 1'b0,
    cnt: 4'h0,
    last: DATA_LAST_8,
    state: TX_IDLE,
    line: 1'b1,
    oe: 1'b0
  };

  tx_regs_t s;
  tx_regs_t n;

  logic req;
  logic wr;
  logic wr_rctl;
  logic wr_ien;
  logic wr_txctl;
  logic wr_txbuf;
  logic wr_div;
  logic tx_on;
  logic bit_tick;
  logic stop_done;
  logic empty_now;
  logic load;
  logic [7:0] wdat;

  // a read is sampled once per cycle; ack is registered, one cycle late
  assign req = wb_cyc_in && wb_stb_in && !s.ack;
  // writes land on the edge where the master sees ack
  assign wr = wb_cyc_in && wb_stb_in && wb_we_in && s.ack && wb_sel_in[0];
  assign wdat = wb_dat_in[7:0];
  assign wr_rctl = wr && (wb_adr_in == ADR_RCTL);
  assign wr_ien = wr && (wb_adr_in == ADR_IEN);
  assign wr_txctl = wr && (wb_adr_in == ADR_TXCTL);
  assign wr_txbuf = wr && (wb_adr_in == ADR_TXBUF);
  assign wr_div = wr && (wb_adr_in == ADR_DIV);

  // asynchronous only with clocked mode clear
  assign tx_on = s.txctl[TXC_EN] && !s.txctl[TXC_SYNC];
  assign stop_done = (s.state == TX_STOP) && bit_tick;
  // empty once the stop bit is out
  assign empty_now = !s.tsr_full || stop_done;
  // the write cycle wins; the move follows one cycle later
  assign load = tx_on && s.hb_full && empty_now && !wr_txbuf && !sleep_in;

  // one divisor and one speed bit serve both directions
  baud_gen #(
    .DIV_W(DIV_W)
  ) u_baud_gen (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .divisor_in(s.div[DIV_W-1:0]),
    .div_write_in(wr_div),
    .high_speed_in(s.txctl[TXC_HS]),
    .halt_in(sleep_in),
    .bit_tick_out(bit_tick)
  );

  always_comb begin
    n = s;
    n.ack = req;
    if (req) begin
      case (wb_adr_in)
        ADR_FLAGS: begin
          n.rdat = 8'h00;
          n.rdat[FLAG_TXE_BIT] = s.flag;
        end
        ADR_RCTL: n.rdat = s.rctl;
        ADR_TXBUF: n.rdat = s.hb;
        ADR_IEN: n.rdat = s.ien;
        ADR_TXCTL: begin
          n.rdat = s.txctl;
          n.rdat[TXC_EMPTY] = !s.tsr_full;
        end
        ADR_DIV: n.rdat = s.div;
        default: n.rdat = 8'h00;
      endcase
    end
    if (wr_rctl) begin
      n.rctl = wdat & RCTL_WR_MASK;
    end
    // enable bit only stored; there is no interrupt line here
    if (wr_ien) begin
      n.ien = wdat & IEN_WR_MASK;
    end
    if (wr_div) begin
      n.div = wdat;
    end
    if (wr_txctl) begin
      n.txctl = wdat & TXCTL_WR_MASK;
      if (wdat[TXC_EN] && !s.txctl[TXC_EN]) begin
        n.flag = 1'b1;
      end
    end
    if (wr_txbuf) begin
      n.hb = wdat;
      n.hb_full = 1'b1;
      n.flag = 1'b0;
    end
    if (!tx_on) begin
      n.state = TX_IDLE;
      n.tsr_full = 1'b0;
      n.cnt = 4'h0;
    end else if (!sleep_in) begin
      if (load) begin
        // ninth bit taken as software left it
        n.transmit_shift_register = {s.txctl[TXC_D9], s.hb};
        n.last = s.txctl[TXC_NINE] ? DATA_LAST_9 : DATA_LAST_8;
        n.tsr_full = 1'b1;
        n.hb_full = 1'b0;
        n.flag = 1'b1;
      end
      case (s.state)
        TX_IDLE: begin
          if (s.tsr_full && bit_tick) begin
            n.state = TX_START;
          end
        end
        TX_START: begin
          if (bit_tick) begin
            n.state = TX_DATA;
            n.cnt = 4'h0;
          end
        end
        TX_DATA: begin
          if (bit_tick) begin
            n.transmit_shift_register = {1'b0, s.transmit_shift_register[8:1]};
            if (s.cnt == s.last) begin
              n.state = TX_STOP;
            end else begin
              n.cnt = s.cnt + 4'h1;
            end
          end
        end
        TX_STOP: begin
          if (bit_tick) begin
            // queued word follows without a gap
            if (load) begin
              n.state = TX_START;
            end else begin
              n.state = TX_IDLE;
              n.tsr_full = 1'b0;
            end
          end
        end
        default: n.state = TX_IDLE;
      endcase
    end
    // pin driven only with port enabled
    n.oe = n.rctl[RC_PORT_EN] && n.txctl[TXC_EN] && !n.txctl[TXC_SYNC];
    if (n.state == TX_START) begin
      n.line = 1'b0;
    end else if (n.state == TX_DATA) begin
      n.line = n.transmit_shift_register[0];
    end else begin
      n.line = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s <= S_RESET;
    end else begin
      s <= n;
    end
  end

  assign wb_ack_out = s.ack;
  assign wb_dat_out = {24'h000000, s.rdat};
  assign tx_pin_out = s.line;
  assign tx_pin_oe_out = s.oe;

  start_bit_low_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    s.state == TX_START |-> !s.line
  ) else $error("start bit not low");

  stop_bit_high_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (s.state == TX_DATA && bit_tick && s.cnt == s.last && tx_on && !sleep_in)
      |=> s.state == TX_STOP && s.line
  ) else $error("stop bit missing after last data bit");

  data_lsb_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (s.state == TX_DATA && bit_tick && s.cnt != s.last && tx_on && !sleep_in)
      |=> s.line == $past(s.transmit_shift_register[1])
  ) else $error("data not shifted least significant first");

  load_flag_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    load |=> s.flag && s.tsr_full && !s.hb_full
  ) else $error("buffer move did not set flag");

  flag_clear_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    $fell(s.flag) |-> $past(wr_txbuf)
  ) else $error("flag cleared without buffer write");

  load_after_stop_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    load |-> (!s.tsr_full || (s.state == TX_STOP && bit_tick))
  ) else $error("shift register loaded while busy");

  busy_status_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    s.state != TX_IDLE |-> s.tsr_full
  ) else $error("frame running with empty status");

  enable_flag_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (wr_txctl && wdat[TXC_EN] && !s.txctl[TXC_EN] && !wr_txbuf) |=> s.flag
  ) else $error("enable did not set flag");

  frame_start_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (s.state == TX_IDLE && tx_on && s.tsr_full && bit_tick && !sleep_in)
      |=> s.state == TX_START
  ) else $error("frame did not start on shift clock");

  back_to_back_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (stop_done && load) |=> s.state == TX_START ##1 !s.line
  ) else $error("queued word did not follow at once");

  abort_float_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    !s.txctl[TXC_EN] |-> !s.oe ##1 (s.state == TX_IDLE && !s.tsr_full)
  ) else $error("disable did not abort and float pin");

  port_gate_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    s.oe |-> s.rctl[RC_PORT_EN] && s.txctl[TXC_EN]
  ) else $error("pin driven while port disabled");

  sleep_hold_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (sleep_in && tx_on) |=> $stable(s.state) && $stable(s.transmit_shift_register)
  ) else $error("frame advanced during sleep");

  idle_high_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (s.oe && (s.state == TX_IDLE || s.state == TX_STOP)) |-> s.line
  ) else $error("line not high between frames");

endmodule : async_serial_transmitter

// file: tb/serial_peer.sv
/*
  Serial peer: a terminal listening on the transmit line.
  Assumes the bench resolves the line with its pull-up and sets the
  bit time in clocks and the frame length.
*/
`timescale 1ns/1ps
module serial_peer (
  input wire logic sys_clk_in,
  input wire logic line_in,
  input wire logic nine_in,
  input wire logic [31:0] bit_clks_in,
  output logic [8:0] word_out,
  output int count_out,
  output logic frame_err_out
);
  logic [8:0] w;
  initial begin
    word_out = '0;
    count_out = 0;
    frame_err_out = 1'b0;
  end
  always begin
    @(negedge line_in);
    repeat (bit_clks_in / 2) @(posedge sys_clk_in);
    if (line_in === 1'b0) begin
      w = '0;
      for (int i = 0; i < (nine_in ? 9 : 8); i++) begin
        repeat (bit_clks_in) @(posedge sys_clk_in);
        w[i] = line_in;
      end
      repeat (bit_clks_in) @(posedge sys_clk_in);
      frame_err_out <= (line_in !== 1'b1);
      word_out <= w;
      count_out <= count_out + 1;
    end
  end
endmodule : serial_peer

// file: tb/tb.sv
/*
  Bench for the serial transmitter: Wishbone register tasks and a
  listening peer on the pulled-up transmit line.
  Assumes the design's own assertions guard cycle-level timing.
*/
`timescale 1ns/1ps
module tb;
  import uart_tx_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic sleep = 1'b0;
  logic nine = 1'b0;
  logic [WB_ADR_W-1:0] adr = '0;
  logic [WB_SEL_W-1:0] sel = 4'hf;
  logic [WB_DAT_W-1:0] dat = '0;
  logic [WB_DAT_W-1:0] rdat;
  logic [31:0] rd;
  logic ack, pin, oe, ferr;
  logic [8:0] word;
  wire logic line;
  int cnt, waited, n;
  int bclk = 16;
  int n_fail = 0;
  int check_count = 0;
  logic [7:0] dvs [3] = '{8'h00, 8'h02, 8'h00};
  logic hss [3] = '{1'b1, 1'b1, 1'b0};
  logic [7:0] dats [3] = '{8'hc5, 8'h3a, 8'h81};
  logic [7:0] rsts [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
  logic [WB_ADR_W-1:0] adrs [6] = '{ADR_FLAGS, ADR_RCTL, ADR_TXBUF,
      ADR_IEN, ADR_TXCTL, ADR_DIV};
  // released pin floats to the pull-up level
  assign line = oe ? pin : 1'b1;
  initial begin
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  async_serial_transmitter #(.DIV_W(8)) u_async_serial_transmitter (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(dat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .sleep_in(sleep), .tx_pin_out(pin), .tx_pin_oe_out(oe));
  serial_peer u_serial_peer (
    .sys_clk_in(sys_clk_in), .line_in(line), .nine_in(nine),
    .bit_clks_in(bclk), .word_out(word), .count_out(cnt),
    .frame_err_out(ferr));
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check
  task automatic wb(input logic w, input logic [WB_ADR_W-1:0] a,
      input logic [7:0] d);
    int t;
    t = 0;
    @(posedge sys_clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    do begin
      @(posedge sys_clk_in);
      t++;
    end while (ack !== 1'b1 && t < 50);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (t >= 50) n_fail++;
  endtask : wb
  task automatic wr(input logic [WB_ADR_W-1:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [WB_ADR_W-1:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    check(rd, {24'h0, e});
  endtask : rdc
  task automatic oe_is(input logic e);
    repeat (2) @(posedge sys_clk_in);
    check({31'h0, oe}, {31'h0, e});
  endtask : oe_is
  task automatic wait_cnt(input int goal);
    int t;
    t = 0;
    while (cnt < goal && t < 5000) begin
      @(posedge sys_clk_in);
      t++;
    end
    waited = t;
    check(32'(cnt), 32'(goal));
  endtask : wait_cnt
  // software keeps the setup order, ninth bit before data
  task automatic setup(input logic [7:0] dv, input logic hs,
      input logic n9, input logic d9);
    wr(ADR_DIV, dv);
    wr(ADR_TXCTL, {5'h00, hs, 2'h0});
    wr(ADR_RCTL, 8'h80);
    wr(ADR_IEN, 8'h10);
    wr(ADR_TXCTL, {1'b0, n9, 3'h0, hs, 2'h0});
    wr(ADR_TXCTL, {1'b0, n9, 3'h4, hs, 2'h0});
    wr(ADR_TXCTL, {1'b0, n9, 3'h4, hs, 1'b0, d9});
    nine = n9;
    bclk = (int'(dv) + 1) * (hs ? 16 : 64);
  endtask : setup
  task automatic summarize();
    $display("checks=%0d failures=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  initial begin
    repeat (40000) @(posedge sys_clk_in);
    n_fail++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    for (int i = 0; i < 6; i++) rdc(adrs[i], rsts[i]);
    rdc(10'h3fc, 8'h00);
    sel <= 4'he;
    wr(ADR_DIV, 8'h55);
    sel <= 4'hf;
    rdc(ADR_DIV, 8'h00);
    for (int i = 0; i < 3; i++) begin
      setup(dvs[i], hss[i], 1'b0, 1'b0);
      rdc(ADR_FLAGS, 8'h10);
      rdc(ADR_IEN, 8'h10);
      rdc(ADR_DIV, dvs[i]);
      rdc(ADR_RCTL, 8'h80);
      oe_is(1'b1);
      check({31'h0, line}, 32'h1);
      n = cnt;
      wr(ADR_TXBUF, dats[i]);
      rdc(ADR_TXCTL, {5'h04, hss[i], 2'h0});
      wr(ADR_FLAGS, 8'h00);
      rdc(ADR_FLAGS, 8'h10);
      wait_cnt(n + 1);
      check(32'(word), {24'h0, dats[i]});
    end
    setup(8'h00, 1'b1, 1'b0, 1'b0);
    n = cnt;
    wr(ADR_TXBUF, 8'ha3);
    wr(ADR_TXBUF, 8'h3c);
    rdc(ADR_FLAGS, 8'h00);
    wait_cnt(n + 1);
    check(32'(word), 32'ha3);
    wait_cnt(n + 2);
    check(32'(word), 32'h3c);
    check(32'(waited), 32'(10 * bclk));
    repeat (bclk) @(posedge sys_clk_in);
    n = cnt;
    sleep <= 1'b1;
    wr(ADR_TXBUF, 8'h96);
    repeat (300) @(posedge sys_clk_in);
    rdc(ADR_TXCTL, 8'h26);
    check(32'(cnt), 32'(n));
    sleep <= 1'b0;
    wait_cnt(n + 1);
    check(32'(word), 32'h96);
    setup(8'h00, 1'b1, 1'b1, 1'b1);
    n = cnt;
    wr(ADR_TXBUF, 8'h81);
    wait_cnt(n + 1);
    check(32'(word), 32'h181);
    check({31'h0, ferr}, 32'h0);
    wr(ADR_TXBUF, 8'h0f);
    repeat (5 * bclk) @(posedge sys_clk_in);
    wr(ADR_TXCTL, 8'h44);
    oe_is(1'b0);
    rdc(ADR_TXCTL, 8'h46);
    repeat (20 * bclk) @(posedge sys_clk_in);
    wr(ADR_TXCTL, 8'h34);
    oe_is(1'b0);
    wr(ADR_TXCTL, 8'h24);
    oe_is(1'b1);
    nine = 1'b0;
    wr(ADR_TXCTL, 8'h04);
    n = cnt;
    wr(ADR_TXBUF, 8'h5a);
    wr(ADR_TXCTL, 8'h24);
    rdc(ADR_FLAGS, 8'h10);
    wait_cnt(n + 1);
    check(32'(word), 32'h5a);
    wr(ADR_RCTL, 8'h00);
    oe_is(1'b0);
    summarize();
  end
endmodule : tb
